//--- logic/flsp_host.sv
// Host controller: status polling and chip protection for a parallel flash
// Behaviour
// - Two reads; unchanged toggle means finished
// - Toggling with timeout high: recheck, else reset
// - Resumed polling restarts with double read
// - After timeout, reset command before more work
// - Check window before and after sector add
// - Write needs ce, strobe low, oe high
// - Protect: high level on a9, oe; a6 low
// - Unprotect: high level, a6 high, strobe pulse
`timescale 1ns/1ps
`default_nettype none
module flsp_host #(
  parameter int UNPROT_CYC = flsp_pkg::WPP2_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output flsp_pkg::flsp_pins_t pins,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o,
  output logic dq_oe_n
);
  // ----------------------------------------
  // Register slave
  // ----------------------------------------
  logic ack_r;
  logic [31:0] dat_r;
  logic [17:0] addr_r;
  logic [7:0] wdata_r;
  logic [7:0] rdata_r;
  logic [7:0] prev_r;
  logic [3:0] op_r;
  logic [1:0] res_r;
  logic done_r;
  logic abort_r;
  wire logic req = wb_cyc_i && wb_stb_i;
  wire logic wr_take = req && wb_we_i && ack_r;
  wire logic sel_ctrl = (wb_adr_i == flsp_pkg::REG_CTRL);
  wire logic sel_addr = (wb_adr_i == flsp_pkg::REG_ADDR);
  wire logic sel_wdata = (wb_adr_i == flsp_pkg::REG_WDATA);
  wire logic sel_rdata = (wb_adr_i == flsp_pkg::REG_RDATA);
  wire logic sel_status = (wb_adr_i == flsp_pkg::REG_STATUS);
  wire logic lane0 = wb_sel_i[0];
  wire logic lane1 = wb_sel_i[1];
  wire logic busy;
  wire logic go = wr_take && sel_ctrl && lane0 && !busy && (wb_dat_i[3:0] != 4'h0);
  wire logic abort_wr = wr_take && sel_ctrl && lane1 && wb_dat_i[flsp_pkg::CTRL_ABORT_BIT];
  wire logic [31:0] status_word = {8'h00, prev_r, rdata_r, 4'h0, res_r, done_r, busy};
  wire logic [31:0] rd_mux = sel_ctrl ? {28'h0000000, op_r} :
                             sel_addr ? {14'h0000, addr_r} :
                             sel_wdata ? {24'h000000, wdata_r} :
                             sel_rdata ? {24'h000000, rdata_r} :
                             sel_status ? status_word : 32'h00000000;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= req && !ack_r;
      dat_r <= rd_mux;
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  typedef enum logic [3:0] {
    M_IDLE = 4'h0,
    M_RD1 = 4'h1,
    M_RD2 = 4'h3,
    M_RD3 = 4'h2,
    M_RD4 = 4'h6,
    M_WR = 4'h7,
    M_RST = 4'h5,
    M_HV = 4'h4,
    M_FIN = 4'hC
  } flsp_st_t;
  flsp_st_t st_r, st_nxt;
  logic wait_r;
  logic hv_r;
  logic [1:0] res_nxt;
  wire logic cyc_done;
  wire logic [7:0] cyc_rdata;
  assign busy = (st_r != M_IDLE);
  wire logic run = busy && (st_r != M_FIN);
  wire logic cyc_start = run && !wait_r;
  wire logic is_rd = (st_r == M_RD1) || (st_r == M_RD2) || (st_r == M_RD3) || (st_r == M_RD4);
  wire logic [1:0] cyc_kind = is_rd ? flsp_pkg::CYC_READ :
                              (st_r == M_HV) ? flsp_pkg::CYC_HV : flsp_pkg::CYC_WRITE;
  wire logic [21:0] cyc_width = is_rd ? 22'(flsp_pkg::ACC_CYC) :
      (st_r != M_HV) ? 22'(flsp_pkg::WP_CYC) :
      (op_r == flsp_pkg::OP_PROTECT) ? 22'(flsp_pkg::WPP1_CYC) : 22'(UNPROT_CYC);
  // Protect holds a6 low during pulse
  // Unprotect holds a6 high during pulse
  wire logic [17:0] hv_addr = (op_r == flsp_pkg::OP_UNPROTECT) ?
      (addr_r | 18'h00040) : (addr_r & 18'h3FFBF);
  wire logic [17:0] cyc_addr = (op_r == flsp_pkg::OP_VERIFY) ? (addr_r | 18'h00002) :
                               (st_r == M_HV) ? hv_addr : addr_r;
  wire logic [7:0] cyc_wdata = (st_r == M_RST) ? flsp_pkg::CMD_RESET :
      (op_r == flsp_pkg::OP_ADD_SECTOR) ? flsp_pkg::CMD_SECTOR_ERASE : wdata_r;
  wire logic tog_same = (cyc_rdata[flsp_pkg::DB_TOGGLE] == prev_r[flsp_pkg::DB_TOGGLE]);
  wire logic tmo_high = cyc_rdata[flsp_pkg::DB_TIMEOUT];
  wire logic win_high = cyc_rdata[flsp_pkg::DB_WINDOW];
  wire logic is_poll = (op_r == flsp_pkg::OP_POLL);
  always_comb begin
    st_nxt = st_r;
    res_nxt = res_r;
    case (st_r)
      M_IDLE: begin
        if (go) begin
          res_nxt = flsp_pkg::RES_OK;
          case (wb_dat_i[3:0])
            flsp_pkg::OP_WRITE: st_nxt = M_WR;
            flsp_pkg::OP_PROTECT, flsp_pkg::OP_UNPROTECT: st_nxt = M_HV;
            default: st_nxt = M_RD1;
          endcase
        end
      end
      M_RD1: begin
        if (cyc_done) begin
          if (op_r == flsp_pkg::OP_ADD_SECTOR) begin
            st_nxt = win_high ? M_FIN : M_WR;
            res_nxt = win_high ? flsp_pkg::RES_CLOSED : flsp_pkg::RES_OK;
          end else begin
            st_nxt = is_poll ? M_RD2 : M_FIN;
          end
        end
      end
      M_RD2: begin
        if (cyc_done) begin
          if (!is_poll) begin
            st_nxt = M_FIN;
            res_nxt = win_high ? flsp_pkg::RES_CLOSED : flsp_pkg::RES_OK;
          end else if (tog_same) begin
            st_nxt = M_FIN;
          end else if (tmo_high) begin
            st_nxt = M_RD3;
          end else if (abort_r) begin
            st_nxt = M_FIN;
            res_nxt = flsp_pkg::RES_ABORTED;
          end else begin
            st_nxt = M_RD1;
          end
        end
      end
      M_RD3: begin
        if (cyc_done) begin
          st_nxt = M_RD4;
        end
      end
      M_RD4: begin
        if (cyc_done) begin
          st_nxt = tog_same ? M_FIN : M_RST;
          res_nxt = tog_same ? flsp_pkg::RES_OK : flsp_pkg::RES_FAIL;
        end
      end
      M_WR: begin
        if (cyc_done) begin
          st_nxt = (op_r == flsp_pkg::OP_ADD_SECTOR) ? M_RD2 : M_FIN;
        end
      end
      M_RST: begin
        if (cyc_done) begin
          st_nxt = M_FIN;
        end
      end
      M_HV: begin
        if (cyc_done) begin
          st_nxt = M_FIN;
        end
      end
      M_FIN: st_nxt = M_IDLE;
      default: st_nxt = M_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= M_IDLE;
      wait_r <= 1'b0;
      res_r <= flsp_pkg::RES_OK;
      done_r <= 1'b0;
      op_r <= 4'h0;
      abort_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      res_r <= res_nxt;
      wait_r <= cyc_start ? 1'b1 : (cyc_done ? 1'b0 : wait_r);
      done_r <= (st_r == M_FIN) ? 1'b1 : (go ? 1'b0 : done_r);
      op_r <= go ? wb_dat_i[3:0] : op_r;
      abort_r <= (abort_wr && busy) ? 1'b1 : ((st_r == M_FIN || go) ? 1'b0 : abort_r);
    end
  end
  // Read results: prev keeps the previous sample for toggle compare
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
      prev_r <= 8'h00;
      addr_r <= 18'h00000;
      wdata_r <= 8'h00;
      hv_r <= 1'b0;
    end else begin
      if (cyc_done && is_rd) begin
        prev_r <= cyc_rdata;
        rdata_r <= cyc_rdata;
      end
      if (wr_take && sel_addr && !busy) begin
        addr_r <= wb_dat_i[17:0];
      end
      if (wr_take && sel_wdata && lane0 && !busy) begin
        wdata_r <= wb_dat_i[7:0];
      end
      // High level held over the whole protect, unprotect or verify op
      hv_r <= (st_nxt == M_HV) ||
              ((op_r == flsp_pkg::OP_VERIFY) && (st_nxt == M_RD1));
    end
  end
  // ----------------------------------------
  // Pin cycle engine
  // ----------------------------------------
  wire logic [17:0] pin_addr;
  wire logic pin_ce_n;
  wire logic pin_oe_n;
  wire logic pin_we_n;
  flsp_cycle u_cycle (
    .clk(clk),
    .rst_b(rst_b),
    .start(cyc_start),
    .kind(cyc_kind),
    .addr(cyc_addr),
    .wdata(cyc_wdata),
    .width(cyc_width),
    .dq_i(dq_i),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .addr_o(pin_addr),
    .ce_n(pin_ce_n),
    .oe_n(pin_oe_n),
    .we_n(pin_we_n),
    .dq_o(dq_o),
    .dq_oe_n(dq_oe_n)
  );
  // High level on a9 and oe for protect
  assign pins = '{addr: pin_addr, chip_select_n: pin_ce_n, output_enable_n: pin_oe_n,
                  write_strobe_n: pin_we_n, hv_address_bit_9: hv_r,
                  hv_output_enable: hv_r && (op_r != flsp_pkg::OP_VERIFY)};
endmodule : flsp_host
`default_nettype wire

//--- logic/flsp_pkg.sv
// Package: constants and pin carrier for the flash status/protection host controller
package flsp_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_PS = 4000;
  localparam int T_ACC_NS = 120;
  localparam int T_WP_NS = 50;
  localparam int T_WPH_NS = 20;
  localparam int T_VLHT_US = 4;
  localparam int T_WPP1_US = 10;
  localparam int T_WPP2_MS = 12;
  localparam int ACC_CYC = (T_ACC_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int WP_CYC = (T_WP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int WPH_CYC = (T_WPH_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int VLHT_CYC = (T_VLHT_US * 1000000 + CLK_PS - 1) / CLK_PS;
  localparam int WPP1_CYC = (T_WPP1_US * 1000000 + CLK_PS - 1) / CLK_PS;
  // Milliseconds in picoseconds overflow an int, so divide first
  localparam int WPP2_CYC = T_WPP2_MS * (1000000000 / CLK_PS);
  localparam int CNT_W = 22;
  // ----------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int CTRL_ABORT_BIT = 8;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_RES_LSB = 2;
  localparam int ST_LAST_LSB = 8;
  localparam int ST_PREV_LSB = 16;
  // ----------------------------------------
  // Operations, results, device bits
  // ----------------------------------------
  localparam logic [3:0] OP_READ = 4'h1;
  localparam logic [3:0] OP_WRITE = 4'h2;
  localparam logic [3:0] OP_POLL = 4'h3;
  localparam logic [3:0] OP_ADD_SECTOR = 4'h4;
  localparam logic [3:0] OP_PROTECT = 4'h5;
  localparam logic [3:0] OP_UNPROTECT = 4'h6;
  localparam logic [3:0] OP_VERIFY = 4'h7;
  localparam logic [1:0] RES_OK = 2'h0;
  localparam logic [1:0] RES_FAIL = 2'h1;
  localparam logic [1:0] RES_CLOSED = 2'h2;
  localparam logic [1:0] RES_ABORTED = 2'h3;
  localparam int DB_TOGGLE = 6;
  localparam int DB_TIMEOUT = 5;
  localparam int DB_WINDOW = 3;
  localparam int DB_SECTOR_TOGGLE = 2;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam int ADDR_W = 18;
  localparam int ADDR_BIT_1 = 1;
  localparam int ADDR_BIT_6 = 6;
  // ----------------------------------------
  // Cycle kinds and pin carrier
  // ----------------------------------------
  localparam logic [1:0] CYC_READ = 2'h0;
  localparam logic [1:0] CYC_WRITE = 2'h1;
  localparam logic [1:0] CYC_HV = 2'h2;
  typedef struct packed {
    logic [17:0] addr;
    logic chip_select_n;
    logic output_enable_n;
    logic write_strobe_n;
    logic hv_address_bit_9;
    logic hv_output_enable;
  } flsp_pins_t;
endpackage : flsp_pkg

//--- logic/flsp_cycle.sv
// One strobed read, write or high-voltage pulse on the flash pins
`timescale 1ns/1ps
`default_nettype none
module flsp_cycle (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [1:0] kind,
  input wire logic [17:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [21:0] width,
  input wire logic [7:0] dq_i,
  output logic done,
  output logic [7:0] rdata,
  output logic [17:0] addr_o,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [7:0] dq_o,
  output logic dq_oe_n
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [2:0] {
    CY_IDLE = 3'h0,
    CY_SETUP = 3'h1,
    CY_PULSE = 3'h3,
    CY_HOLD = 3'h2,
    CY_DONE = 3'h6
  } flsp_cy_t;
  flsp_cy_t st_r, st_nxt;
  logic [21:0] cnt_r, cnt_nxt;
  logic [1:0] kind_r;
  logic [21:0] width_r;
  wire logic cnt_end = (cnt_r == 22'h000000);
  wire logic is_rd = (kind_r == flsp_pkg::CYC_READ);
  wire logic [21:0] setup_cyc = (kind_r == flsp_pkg::CYC_HV) ?
      22'(flsp_pkg::VLHT_CYC - 1) : 22'h000000;
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_end ? cnt_r : cnt_r - 22'h000001;
    case (st_r)
      CY_IDLE: begin
        if (start) begin
          st_nxt = CY_SETUP;
          cnt_nxt = 22'h000000;
        end
      end
      CY_SETUP: begin
        // Long setup stays here so no early strobe edge leaks out
        if (cnt_end && setup_cyc != 22'h000000) begin
          cnt_nxt = setup_cyc;
        end else if (cnt_end) begin
          st_nxt = CY_PULSE;
          cnt_nxt = width_r - 22'h000001;
        end
      end
      CY_PULSE: begin
        if (cnt_end) begin
          st_nxt = CY_HOLD;
          cnt_nxt = 22'(flsp_pkg::WPH_CYC - 1);
        end
      end
      CY_HOLD: begin
        if (cnt_end) begin
          st_nxt = CY_DONE;
        end
      end
      CY_DONE: st_nxt = CY_IDLE;
      default: st_nxt = CY_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= CY_IDLE;
      cnt_r <= 22'h000000;
      kind_r <= flsp_pkg::CYC_READ;
      width_r <= 22'h000001;
      addr_o <= 18'h00000;
      dq_o <= 8'h00;
      rdata <= 8'h00;
    end else begin
      st_r <= st_nxt;
      cnt_r <= (st_r == CY_IDLE && start) ? 22'h000000 :
               (st_r == CY_IDLE) ? cnt_r : cnt_nxt;
      if (st_r == CY_IDLE && start) begin
        kind_r <= kind;
        width_r <= width;
        addr_o <= addr;
        dq_o <= wdata;
      end
      if (st_r == CY_SETUP && cnt_end && setup_cyc != 22'h000000) begin
        kind_r <= flsp_pkg::CYC_WRITE;
      end
      if (st_r == CY_PULSE && cnt_end && is_rd) begin
        rdata <= dq_i;
      end
    end
  end
  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  // Write only with ce low, oe high
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      dq_oe_n <= 1'b1;
    end else begin
      ce_n <= !(st_nxt == CY_SETUP || st_nxt == CY_PULSE);
      oe_n <= !(st_nxt == CY_PULSE && is_rd);
      we_n <= !(st_nxt == CY_PULSE && !is_rd && st_r != CY_IDLE);
      dq_oe_n <= !(st_nxt != CY_IDLE && st_nxt != CY_DONE && !is_rd && st_r != CY_IDLE);
    end
  end
  assign done = (st_r == CY_DONE);
endmodule : flsp_cycle
`default_nettype wire

//--- dv/flsp_host_monitor.sv
// Checker: pin relations of the flash host controller
`timescale 1ns/1ps
`default_nettype none
module flsp_host_monitor #(
  parameter int UNPROT_CYC = flsp_pkg::WPP2_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire flsp_pkg::flsp_pins_t pins,
  input wire logic [7:0] dq_i,
  input wire logic [7:0] dq_o,
  input wire logic dq_oe_n
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire wr_lo = !pins.write_strobe_n;
  wire hv = pins.hv_output_enable;
  property p_wr_gate;
    wr_lo && !hv |-> !pins.chip_select_n && pins.output_enable_n;
  endproperty
  a_wr_gate: assert property (p_wr_gate) else $error("strobe outside write cycle");
  property p_wr_data;
    wr_lo && !hv |-> !dq_oe_n;
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write without data");
  property p_no_fight;
    !pins.output_enable_n |-> dq_oe_n;
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("data driven during read");
  property p_we_width;
    $fell(pins.write_strobe_n) |=> !pins.write_strobe_n [*2];
  endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe too short");
  property p_ce_width;
    $fell(pins.chip_select_n) |=> !pins.chip_select_n [*2];
  endproperty
  a_ce_width: assert property (p_ce_width) else $error("select too short");
  property p_prot_pins;
    hv && wr_lo |-> pins.hv_address_bit_9 && !pins.chip_select_n;
  endproperty
  a_prot_pins: assert property (p_prot_pins) else $error("protect pins wrong");
  property p_hv_hold;
    wr_lo && $past(wr_lo) |-> $stable(pins.addr);
  endproperty
  a_hv_hold: assert property (p_hv_hold) else $error("address moved in pulse");
  property p_verify;
    pins.hv_address_bit_9 && !pins.output_enable_n |->
      pins.addr[1] && !wr_lo && !pins.chip_select_n && !hv;
  endproperty
  a_verify: assert property (p_verify) else $error("verify read pins wrong");
  property p_boot_idle;
    !$past(rst_b) |-> pins.write_strobe_n && pins.chip_select_n;
  endproperty
  a_boot_idle: assert property (p_boot_idle) else $error("strobe active at start");
  c_write: cover property (!hv && $fell(pins.write_strobe_n));
  c_hv_pulse: cover property (hv && $fell(pins.write_strobe_n));
  c_verify: cover property (pins.hv_address_bit_9 && $fell(pins.output_enable_n));
endmodule : flsp_host_monitor
bind flsp_host flsp_host_monitor #(.UNPROT_CYC(UNPROT_CYC)) i_flsp_host_monitor (
  .clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .pins(pins), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_n(dq_oe_n));
`default_nettype wire

//--- dv/flsp_flash_model.sv
// Behavioural flash: status bits and chip protection
`timescale 1ns/1ps
`default_nettype none
module flsp_flash_model #(
  parameter logic [4:0] SECT = 5'h1F,
  // Arbitrary identification byte
  parameter logic [7:0] ID_CODE = 8'h5A
) (
  input wire logic clk,
  input wire flsp_pkg::flsp_pins_t pins,
  input wire logic [7:0] dq_o,
  input wire logic dq_oe_n,
  input wire logic load,
  input wire logic [7:0] load_reads,
  input wire logic load_to,
  input wire logic load_win,
  output logic [7:0] dq_i
);
  logic [7:0] cnt = 8'h00;
  logic [7:0] last = 8'h00;
  logic [7:0] wr_last = 8'h00;
  logic tog = 1'b0, tog2 = 1'b0, to = 1'b0, win = 1'b0, prot = 1'b0;
  logic oe_q = 1'b1, we_q = 1'b1, ce_q = 1'b1;
  int adds = 0;
  wire [7:0] stat = {1'b0, tog, to, 1'b0, win, tog2, 2'b00};
  // a1 low gives identification, not protection
  wire [7:0] id_prot = pins.addr[1] ? {7'h00, prot} : ID_CODE;
  wire [7:0] byte_o = pins.hv_address_bit_9 ? id_prot : stat;
  // Released bus shows inverse, not a stale copy
  assign dq_i = (!pins.chip_select_n && !pins.output_enable_n) ? byte_o : ~last;
  always @(posedge clk) begin
    oe_q <= pins.output_enable_n;
    we_q <= pins.write_strobe_n;
    ce_q <= pins.chip_select_n;
    if (load) begin
      cnt <= load_reads;
      to <= load_to;
      win <= load_win;
      tog <= 1'b0;
      tog2 <= 1'b0;
    end else if (!oe_q && !ce_q && pins.output_enable_n) begin
      last <= byte_o;
      if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
        tog <= ~tog;
        if (pins.addr[17:13] == SECT) tog2 <= ~tog2;
      end
    end else if (!we_q && !ce_q && pins.write_strobe_n) begin
      if (pins.hv_output_enable) prot <= !pins.addr[6];
      else if (pins.output_enable_n && !dq_oe_n) begin
        wr_last <= dq_o;
        if (dq_o == 8'hF0) begin
          cnt <= 8'h00;
          to <= 1'b0;
        end
        // sector add only while window open
        if (dq_o == 8'h30 && !win) adds <= adds + 1;
      end
    end
  end
endmodule : flsp_flash_model
`default_nettype wire

//--- dv/flsp_host_tb_top.sv
// Testbench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module flsp_host_tb_top;
  logic clk, rst_b, cyc, stb, we, cmp_on, ack, dq_oe_n, load, load_to, load_win;
  logic [7:0] adr, dq_o, dq_i, load_reads, rd;
  logic [3:0] sel;
  logic [31:0] dat, dat_o, q;
  logic [63:0] n;
  logic [17:0] ra;
  logic [63:0] notes[$];
  int mismatches = 0, checks_done = 0;
  flsp_pkg::flsp_pins_t pins;
  flsp_host #(.UNPROT_CYC(20)) i_flsp_host (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .pins(pins), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_n(dq_oe_n));
  flsp_flash_model i_flsp_flash_model (.clk(clk), .pins(pins), .dq_o(dq_o), .dq_oe_n(dq_oe_n),
    .load(load), .load_reads(load_reads), .load_to(load_to), .load_win(load_win), .dq_i(dq_i));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  // Oldest note judges each checked read
  always @(posedge clk) begin
    if (ack === 1'b1 && cmp_on && !we) begin
      n = notes.pop_front();
      check(dat_o & n[31:0], n[63:32]);
    end
  end
  // ----------------------------------------
  // Bus and operation tasks
  // ----------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic c, input logic [31:0] e, input logic [31:0] m);
    if (c) notes.push_back({e, m});
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    cmp_on <= c;
    do @(posedge clk); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    cmp_on <= 1'b0;
  endtask : bus
  // Abort is sent right after start; the poll sees it at its next decision
  task automatic op(input logic [3:0] o, input logic [1:0] res, input logic ab);
    bus(1'b1, 8'h00, {28'h0, o}, 1'b0, 32'h0, 32'h0);
    if (ab) bus(1'b1, 8'h00, 32'h100, 1'b0, 32'h0, 32'h0);
    q = 32'h1;
    while (q[1:0] != 2'b10) bus(1'b0, 8'h10, 32'h0, 1'b0, 32'h0, 32'h0);
    bus(1'b0, 8'h10, 32'h0, 1'b1, {28'h0, res, 2'b10}, 32'hF);
  endtask : op
  task automatic ld(input logic [7:0] k, input logic t, input logic w);
    @(posedge clk);
    load <= 1'b1;
    load_reads <= k;
    load_to <= t;
    load_win <= w;
    @(posedge clk);
    load <= 1'b0;
  endtask : ld
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    {cyc, stb, we, cmp_on, load, load_to, load_win} = 7'h00;
    {adr, load_reads, dat} = 48'h0;
    sel = 4'hF;
    rst_b = 1'b0;
    void'($urandom(32'h1d158662));
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    ra = 18'($urandom);
    // Top bit set so the byte is never a sector erase command
    rd = 8'($urandom) | 8'h80;
    bus(1'b0, 8'h20, 32'h0, 1'b1, 32'h0, 32'hFFFFFFFF);
    bus(1'b1, 8'h04, {14'h0, ra}, 1'b0, 32'h0, 32'h0);
    bus(1'b0, 8'h04, 32'h0, 1'b1, {14'h0, ra}, 32'h3FFFF);
    bus(1'b1, 8'h08, {24'h0, rd}, 1'b0, 32'h0, 32'h0);
    op(flsp_pkg::OP_WRITE, flsp_pkg::RES_OK, 1'b0);
    check({24'h0, i_flsp_flash_model.wr_last}, {24'h0, rd});
    ld(8'd0, 1'b0, 1'b0);
    op(flsp_pkg::OP_POLL, flsp_pkg::RES_OK, 1'b0);
    ld(8'd3, 1'b0, 1'b0);
    op(flsp_pkg::OP_POLL, flsp_pkg::RES_OK, 1'b0);
    ld(8'd2, 1'b1, 1'b0);
    op(flsp_pkg::OP_POLL, flsp_pkg::RES_OK, 1'b0);
    ld(8'd200, 1'b1, 1'b0);
    op(flsp_pkg::OP_POLL, flsp_pkg::RES_FAIL, 1'b0);
    check({24'h0, i_flsp_flash_model.wr_last}, 32'hF0);
    op(flsp_pkg::OP_POLL, flsp_pkg::RES_OK, 1'b0);
    ld(8'd200, 1'b0, 1'b0);
    op(flsp_pkg::OP_POLL, flsp_pkg::RES_ABORTED, 1'b1);
    // In-sector, outside, in-sector reads of the status byte
    ld(8'd8, 1'b1, 1'b1);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 8'h04, (i == 1) ? 32'h0 : 32'h3E000, 1'b0, 32'h0, 32'h0);
      op(flsp_pkg::OP_READ, flsp_pkg::RES_OK, 1'b0);
      bus(1'b0, 8'h0C, 32'h0, 1'b1, (i == 0) ? 32'h28 : (i == 1) ? 32'h6C : 32'h2C, 32'h6C);
    end
    ld(8'd0, 1'b0, 1'b0);
    op(flsp_pkg::OP_ADD_SECTOR, flsp_pkg::RES_OK, 1'b0);
    ld(8'd0, 1'b0, 1'b1);
    op(flsp_pkg::OP_ADD_SECTOR, flsp_pkg::RES_CLOSED, 1'b0);
    check(32'(i_flsp_flash_model.adds), 32'h1);
    op(flsp_pkg::OP_PROTECT, flsp_pkg::RES_OK, 1'b0);
    op(flsp_pkg::OP_VERIFY, flsp_pkg::RES_OK, 1'b0);
    bus(1'b0, 8'h0C, 32'h0, 1'b1, 32'h1, 32'hFF);
    op(flsp_pkg::OP_UNPROTECT, flsp_pkg::RES_OK, 1'b0);
    op(flsp_pkg::OP_VERIFY, flsp_pkg::RES_OK, 1'b0);
    bus(1'b0, 8'h0C, 32'h0, 1'b1, 32'h0, 32'hFF);
    print_verdict();
  end
endmodule : flsp_host_tb_top
`default_nettype wire
